// ==== rtl/htr_pkg.sv ====
// Function
// RULE1: Eight-bit registers selected by seven-bit address
// RULE2: Identity register at 0F returns fixed code
// RULE3: Averaging config at 10, reset 1B, fields
// RULE4: Temperature code selects 2 to 256 samples
// RULE5: Humidity code selects 4 to 512 samples
// RULE6: Host never writes reserved address ranges
// RULE7: Calibration bytes 30-3F loaded, host leaves them
// RULE8: Run control bit 7 selects active state
// RULE9: Hold bit freezes pair until both halves read
// RULE10: Host sets hold bit when reads slow
// RULE11: Rate field selects one-shot, 1, 7, 12.5 Hz
// RULE12: Rate field resets to one-shot
// RULE13: Reload bit copies trim, then self-clears
// RULE14: Start bit runs one acquisition, then clears
// RULE15: Heater follows host-written bit only
// RULE16: Host avoids reading outputs while heater on
// RULE17: Ready flags set on sample, cleared by high-byte read
// RULE18: Results are 16-bit two's complement byte pairs
// RULE19: Status refreshed after every conversion
// RULE20: Writes to read-only registers are ignored
package htr_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;

   localparam logic [6:0] ADDR_IDENT = 7'h0F;
   localparam logic [6:0] ADDR_AVG = 7'h10;
   localparam logic [6:0] ADDR_RUN = 7'h20;
   localparam logic [6:0] ADDR_SVC = 7'h21;
   localparam logic [6:0] ADDR_ALERT = 7'h22;
   localparam logic [6:0] ADDR_STATUS = 7'h27;
   localparam logic [6:0] ADDR_HUM_L = 7'h28;
   localparam logic [6:0] ADDR_HUM_H = 7'h29;
   localparam logic [6:0] ADDR_TEMP_L = 7'h2A;
   localparam logic [6:0] ADDR_TEMP_H = 7'h2B;
   localparam logic [6:0] ADDR_CALIB_LO = 7'h30;
   localparam logic [6:0] ADDR_CALIB_HI = 7'h3F;
   localparam logic [6:0] ADDR_RSV0_HI = 7'h0E;
   localparam logic [6:0] ADDR_RSV1_LO = 7'h11;
   localparam logic [6:0] ADDR_RSV1_HI = 7'h1C;
   localparam logic [6:0] ADDR_RSV2_LO = 7'h23;
   localparam logic [6:0] ADDR_RSV2_HI = 7'h26;
   localparam logic [6:0] ADDR_RSV3_LO = 7'h2C;

   // Arbitrary identification value
   localparam logic [7:0] IDENT_CODE = 8'h5A;

   localparam logic [7:0] AVG_RST = 8'h1B;
   localparam logic [7:0] RUN_RST = 8'h00;
   localparam logic [7:0] SVC_RST = 8'h00;
   localparam logic [7:0] ALERT_RST = 8'h00;
   localparam logic [7:0] AVG_MASK = 8'h3F;
   localparam logic [7:0] RUN_MASK = 8'h87;
   localparam logic [7:0] SVC_MASK = 8'h83;
   localparam logic [7:0] ALERT_MASK = 8'hC4;

   localparam int TEMP_AVG_SELECT_LSB = 3;
   localparam int HUM_AVG_SELECT_LSB = 0;
   localparam int RUN_ACTIVE_BIT = 7;
   localparam int RUN_HOLD_BIT = 2;
   localparam int RUN_RATE_LSB = 0;
   localparam int SVC_RELOAD_BIT = 7;
   localparam int SVC_HEATER_BIT = 1;
   localparam int SVC_START_BIT = 0;
   localparam int ALERT_LOW_BIT = 7;
   localparam int ALERT_EN_BIT = 2;
   localparam int STAT_HUM_BIT = 1;
   localparam int STAT_TEMP_BIT = 0;

   localparam logic [1:0] RATE_ONE_SHOT = 2'h0;
   localparam logic [1:0] RATE_1HZ = 2'h1;
   localparam logic [1:0] RATE_7HZ = 2'h2;

   // Log2 of smallest sample counts: code n selects 1 << (base + n)
   localparam int TEMP_AVG_BASE_LOG2 = 1;
   localparam int HUM_AVG_BASE_LOG2 = 2;

   localparam longint CLK_HZ = 64'd25000000;
   localparam longint RATE_1HZ_MHZ = 64'd1000;
   localparam longint RATE_7HZ_MHZ = 64'd7000;
   localparam longint RATE_12HZ_MHZ = 64'd12500;
   localparam longint RATE_1HZ_CYC = CLK_HZ * 64'd1000 / RATE_1HZ_MHZ;
   localparam longint RATE_7HZ_CYC = CLK_HZ * 64'd1000 / RATE_7HZ_MHZ;
   localparam longint RATE_12HZ_CYC = CLK_HZ * 64'd1000 / RATE_12HZ_MHZ;

   localparam logic [3:0] BOOT_CYCLES = 4'h8;
   localparam int RATE_CNT_W = 25;

   typedef enum logic [2:0] {
      ST_BOOT = 3'b001,
      ST_IDLE = 3'b010,
      ST_CONV = 3'b100
   } htr_state_t;
endpackage : htr_pkg

// ==== rtl/htr_link_if.sv ====
`timescale 1ns/1ns
interface htr_link_if;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;

   modport dev (
      input addr,
      input wdata,
      input wr,
      input rd,
      output rdata
   );

   modport hst (
      output addr,
      output wdata,
      output wr,
      output rd,
      input rdata
   );
endinterface : htr_link_if

// ==== rtl/htr_device.sv ====
`timescale 1ns/1ns
module htr_device
   import htr_pkg::*;
#(
   parameter int unsigned RATE_1HZ_PERIOD = int'(RATE_1HZ_CYC),
   parameter int unsigned RATE_7HZ_PERIOD = int'(RATE_7HZ_CYC),
   parameter int unsigned RATE_12HZ_PERIOD = int'(RATE_12HZ_CYC)
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Register link
   htr_link_if.dev link,
   // Sensing front end
   input wire logic [15:0] raw_hum_i,
   input wire logic [15:0] raw_temp_i,
   input wire logic [127:0] calib_nvm_i,
   // Status to the board
   output logic active_o,
   output logic heater_o,
   output logic converting_o,
   output logic data_ready_o
);
   typedef struct packed {
      htr_state_t st;
      logic [7:0] avg;
      logic [7:0] run;
      logic [7:0] svc;
      logic [7:0] alert;
      logic [1:0] status;
      logic [15:0] hum_out;
      logic [15:0] temp_out;
      logic [15:0] hum_shadow;
      logic [15:0] temp_shadow;
      logic hum_shadow_v;
      logic temp_shadow_v;
      logic hum_lock;
      logic hum_lock_hi;
      logic temp_lock;
      logic temp_lock_hi;
      logic [15:0][7:0] calib;
      logic [7:0] rdata;
      logic [3:0] boot_cnt;
      logic [9:0] smp_cnt;
      logic signed [25:0] acc_h;
      logic signed [25:0] acc_t;
      logic [RATE_CNT_W-1:0] rate_cnt;
   } htr_dev_state_t;

   htr_dev_state_t s_q;
   htr_dev_state_t s_d;
   logic signed [25:0] sum_h;
   logic signed [25:0] sum_t;
   logic [9:0] hum_count;
   logic [9:0] temp_count;
   logic [RATE_CNT_W-1:0] period;
   logic rate_tick;
   logic [2:0] temp_avg_select;
   logic [2:0] hum_avg_select;

   always_comb begin
      s_d = s_q;
      temp_avg_select = s_q.avg[TEMP_AVG_SELECT_LSB +: 3];
      hum_avg_select = s_q.avg[HUM_AVG_SELECT_LSB +: 3];
      hum_count = 10'(10'h001 << (HUM_AVG_BASE_LOG2 + int'(hum_avg_select))); // RULE5
      temp_count = 10'(10'h001 << (TEMP_AVG_BASE_LOG2 + int'(temp_avg_select))); // RULE4
      sum_h = s_q.acc_h + 26'(signed'(raw_hum_i));
      sum_t = s_q.acc_t;
      if (s_q.smp_cnt < temp_count) begin
         sum_t = s_q.acc_t + 26'(signed'(raw_temp_i));
      end
      unique case (s_q.run[RUN_RATE_LSB +: 2]) // RULE11
         RATE_1HZ: period = RATE_CNT_W'(RATE_1HZ_PERIOD);
         RATE_7HZ: period = RATE_CNT_W'(RATE_7HZ_PERIOD);
         default: period = RATE_CNT_W'(RATE_12HZ_PERIOD);
      endcase
      rate_tick = 1'b0;

      // Periodic timer only runs while active with a rate chosen
      if (s_q.run[RUN_ACTIVE_BIT] && s_q.run[RUN_RATE_LSB +: 2] != RATE_ONE_SHOT) begin // RULE12
         if (s_q.rate_cnt >= period - RATE_CNT_W'(1)) begin
            s_d.rate_cnt = '0;
            rate_tick = 1'b1;
         end else begin
            s_d.rate_cnt = s_q.rate_cnt + RATE_CNT_W'(1);
         end
      end else begin
         s_d.rate_cnt = '0;
      end

      // Register reads, answered one cycle later
      s_d.rdata = 8'h00;
      if (link.rd) begin
         unique case (link.addr) // RULE1
            ADDR_IDENT: s_d.rdata = IDENT_CODE; // RULE2
            ADDR_AVG: s_d.rdata = s_q.avg;
            ADDR_RUN: s_d.rdata = s_q.run;
            ADDR_SVC: s_d.rdata = s_q.svc;
            ADDR_ALERT: s_d.rdata = s_q.alert;
            ADDR_STATUS: s_d.rdata = {6'h00, s_q.status};
            ADDR_HUM_L: s_d.rdata = s_q.hum_out[7:0]; // RULE18
            ADDR_HUM_H: s_d.rdata = s_q.hum_out[15:8];
            ADDR_TEMP_L: s_d.rdata = s_q.temp_out[7:0];
            ADDR_TEMP_H: s_d.rdata = s_q.temp_out[15:8];
            default: begin
               // Bounded above too, so unmapped addresses past the calibration bytes read 0
               if (link.addr >= ADDR_CALIB_LO && link.addr <= ADDR_CALIB_HI) begin
                  s_d.rdata = s_q.calib[link.addr[3:0]];
               end
            end
         endcase
         if (link.addr == ADDR_HUM_H) begin
            s_d.status[STAT_HUM_BIT] = 1'b0; // RULE17
         end
         if (link.addr == ADDR_TEMP_H) begin
            s_d.status[STAT_TEMP_BIT] = 1'b0; // RULE17
         end
         // A pair locks on its first half and frees on the other
         if (link.addr == ADDR_HUM_L || link.addr == ADDR_HUM_H) begin
            if (!s_q.hum_lock) begin
               s_d.hum_lock = s_q.run[RUN_HOLD_BIT]; // RULE9
               s_d.hum_lock_hi = link.addr[0];
            end else if (s_q.hum_lock_hi != link.addr[0]) begin
               s_d.hum_lock = 1'b0; // RULE9
            end
         end
         if (link.addr == ADDR_TEMP_L || link.addr == ADDR_TEMP_H) begin
            if (!s_q.temp_lock) begin
               s_d.temp_lock = s_q.run[RUN_HOLD_BIT]; // RULE9
               s_d.temp_lock_hi = link.addr[0];
            end else if (s_q.temp_lock_hi != link.addr[0]) begin
               s_d.temp_lock = 1'b0; // RULE9
            end
         end
      end
      if (!s_q.run[RUN_HOLD_BIT]) begin
         s_d.hum_lock = 1'b0;
         s_d.temp_lock = 1'b0;
      end

      // Register writes; read-only and reserved addresses fall through
      if (link.wr) begin
         unique case (link.addr)
            ADDR_AVG: s_d.avg = link.wdata & AVG_MASK; // RULE3
            ADDR_RUN: s_d.run = link.wdata & RUN_MASK; // RULE8
            ADDR_SVC: s_d.svc = link.wdata & SVC_MASK; // RULE15
            ADDR_ALERT: s_d.alert = link.wdata & ALERT_MASK;
            default: begin
               if (link.addr >= ADDR_CALIB_LO && link.addr <= ADDR_CALIB_HI) begin
                  s_d.calib[link.addr[3:0]] = link.wdata;
               end
            end
         endcase // RULE20
      end

      unique case (s_q.st)
         ST_BOOT: begin
            s_d.boot_cnt = s_q.boot_cnt + 4'h1;
            if (s_q.boot_cnt == BOOT_CYCLES - 4'h1) begin
               s_d.calib = calib_nvm_i; // RULE7
               s_d.svc[SVC_RELOAD_BIT] = 1'b0; // RULE13
               s_d.st = ST_IDLE;
            end
         end
         ST_IDLE: begin
            s_d.smp_cnt = '0;
            s_d.acc_h = '0;
            s_d.acc_t = '0;
            if (s_q.svc[SVC_RELOAD_BIT]) begin
               s_d.boot_cnt = '0;
               s_d.st = ST_BOOT; // RULE13
            end else if (s_q.run[RUN_ACTIVE_BIT]
                  && (s_q.svc[SVC_START_BIT] || rate_tick)) begin
               s_d.st = ST_CONV; // RULE8
            end
         end
         ST_CONV: begin
            s_d.acc_h = sum_h;
            s_d.acc_t = sum_t;
            s_d.smp_cnt = s_q.smp_cnt + 10'h001;
            if (!s_q.run[RUN_ACTIVE_BIT]) begin
               // Power-down abandons the acquisition
               s_d.st = ST_IDLE;
            end else if (s_q.smp_cnt == hum_count - 10'h001) begin
               s_d.hum_shadow = 16'(sum_h >>> (HUM_AVG_BASE_LOG2 + int'(hum_avg_select)));
               s_d.temp_shadow = 16'(sum_t >>> (TEMP_AVG_BASE_LOG2 + int'(temp_avg_select)));
               s_d.hum_shadow_v = 1'b1;
               s_d.temp_shadow_v = 1'b1;
               s_d.status = 2'h3; // RULE19
               s_d.svc[SVC_START_BIT] = 1'b0; // RULE14
               s_d.st = ST_IDLE;
            end
         end
      endcase

      // New results reach the outputs once the pair is unlocked
      if (s_d.hum_shadow_v && !s_d.hum_lock) begin
         s_d.hum_out = s_d.hum_shadow; // RULE14
         s_d.hum_shadow_v = 1'b0;
      end
      if (s_d.temp_shadow_v && !s_d.temp_lock) begin
         s_d.temp_out = s_d.temp_shadow; // RULE14
         s_d.temp_shadow_v = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.st <= ST_BOOT;
         s_q.avg <= AVG_RST;
         s_q.run <= RUN_RST;
         s_q.svc <= SVC_RST;
         s_q.alert <= ALERT_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.rdata = s_q.rdata;
   assign active_o = s_q.run[RUN_ACTIVE_BIT];
   assign heater_o = s_q.svc[SVC_HEATER_BIT]; // RULE15
   assign converting_o = (s_q.st == ST_CONV);
   assign data_ready_o = (s_q.alert[ALERT_EN_BIT] & (|s_q.status)) ^ s_q.alert[ALERT_LOW_BIT];
endmodule : htr_device

// ==== rtl/htr_host.sv ====
`timescale 1ns/1ns
module htr_host
   import htr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Command side
   input wire logic cmd_valid_i,
   input wire logic cmd_write_i,
   input wire logic [6:0] cmd_addr_i,
   input wire logic [7:0] cmd_wdata_i,
   output logic cmd_ready_o,
   output logic cmd_refused_o,
   output logic rsp_valid_o,
   output logic [7:0] rsp_data_o,
   // Register link
   htr_link_if.hst link
);
   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
      logic rd_wait;
      logic rsp_valid;
      logic [7:0] rsp_data;
      logic refused;
      logic heater;
   } htr_host_state_t;

   htr_host_state_t s_q;
   htr_host_state_t s_d;
   logic protect;
   logic output_addr;

   always_comb begin
      s_d = s_q;
      s_d.wr = 1'b0;
      s_d.rd = 1'b0;
      s_d.refused = 1'b0;
      s_d.rsp_valid = s_q.rd_wait;
      s_d.rd_wait = s_q.rd;
      if (s_q.rd_wait) begin
         s_d.rsp_data = link.rdata;
      end
      protect = (cmd_addr_i <= ADDR_RSV0_HI)
         || (cmd_addr_i >= ADDR_RSV1_LO && cmd_addr_i <= ADDR_RSV1_HI)
         || (cmd_addr_i >= ADDR_RSV2_LO && cmd_addr_i <= ADDR_RSV2_HI)
         || (cmd_addr_i >= ADDR_RSV3_LO); // RULE6 RULE7
      output_addr = (cmd_addr_i >= ADDR_HUM_L && cmd_addr_i <= ADDR_TEMP_H);
      if (cmd_valid_i) begin
         s_d.addr = cmd_addr_i;
         s_d.wdata = cmd_wdata_i;
         if (cmd_write_i) begin
            if (protect) begin
               s_d.refused = 1'b1; // RULE6
            end else begin
               s_d.wr = 1'b1;
               if (cmd_addr_i == ADDR_RUN) begin
                  // Command reads here are not paced, so pairs stay locked
                  s_d.wdata[RUN_HOLD_BIT] = 1'b1; // RULE10
               end
               if (cmd_addr_i == ADDR_SVC) begin
                  s_d.heater = cmd_wdata_i[SVC_HEATER_BIT];
               end
            end
         end else if (output_addr && s_q.heater) begin
            s_d.refused = 1'b1; // RULE16
         end else begin
            s_d.rd = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign cmd_ready_o = !rst_i;
   assign cmd_refused_o = s_q.refused;
   assign rsp_valid_o = s_q.rsp_valid;
   assign rsp_data_o = s_q.rsp_data;
   assign link.addr = s_q.addr;
   assign link.wdata = s_q.wdata;
   assign link.wr = s_q.wr;
   assign link.rd = s_q.rd;
endmodule : htr_host

// ==== dv/htr_asserts.sv ====
`timescale 1ns/1ns
module htr_asserts
   import htr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Register link
   input wire logic [6:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata
);
   logic heat_q;

   // Mirrors the heater bit last sent over the link
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         heat_q <= 1'b0;
      end else if (wr && addr == ADDR_SVC) begin
         heat_q <= wdata[SVC_HEATER_BIT];
      end
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   a_strobe_excl: assert property (!(wr && rd))
      else $error("read and write strobes together");
   a_rdata_slot: assert property (rdata != 8'h00 |-> $past(rd))
      else $error("read data outside its slot");
   a_ident_fixed: assert property (rd && addr == ADDR_IDENT |=> rdata == IDENT_CODE)
      else $error("identity read wrong");
   a_avg_spare: assert property (rd && addr == ADDR_AVG |=> rdata[7:6] == 2'b00)
      else $error("averaging spare bits set");
   a_flag_spare: assert property (rd && addr == ADDR_STATUS |=> rdata[7:2] == 6'h00)
      else $error("status spare bits set");
   a_rsv_write: assert property (wr |-> !(addr <= ADDR_RSV0_HI
      || (addr >= ADDR_RSV1_LO && addr <= ADDR_RSV1_HI)
      || (addr >= ADDR_RSV2_LO && addr <= ADDR_RSV2_HI)
      || (addr >= ADDR_RSV3_LO && addr < ADDR_CALIB_LO)))
      else $error("write to reserved address");
   a_calib_keep: assert property (wr |-> !(addr >= ADDR_CALIB_LO && addr <= ADDR_CALIB_HI))
      else $error("write to calibration bytes");
   a_hold_forced: assert property (wr && addr == ADDR_RUN |-> wdata[RUN_HOLD_BIT])
      else $error("run control written without hold bit");
   a_heater_read: assert property (rd && addr >= ADDR_HUM_L && addr <= ADDR_TEMP_H |-> !heat_q)
      else $error("output read while heater on");

   c_ident_read: cover property (rd && addr == ADDR_IDENT);
   c_hum_high: cover property (rd && addr == ADDR_HUM_H);
   c_heater_on: cover property (wr && addr == ADDR_SVC && wdata[SVC_HEATER_BIT]);
endmodule : htr_asserts

// ==== dv/htr_bench.sv ====
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module htr_bench;
   import htr_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cv = 1'b0;
   logic cw = 1'b0;
   logic [6:0] ca = 7'h00;
   logic [7:0] cd = 8'h00;
   logic [15:0] hum = 16'h0000;
   logic [15:0] tmp = 16'h0000;
   logic [127:0] nvm;
   logic act, heat, conv, drdy, rdy, refd, rv;
   logic [7:0] rdat, q;
   logic r;
   logic [15:0] prev_tmp;
   logic [31:0] seed = 32'h1B2219F1;
   int err_total = 0;
   int cmp_count = 0;
   int n;
   logic [6:0] rsv [10] = '{7'h00, 7'h0E, 7'h11, 7'h1C, 7'h23, 7'h26, 7'h2C, 7'h2F, 7'h30, 7'h3F};

   htr_link_if link_if ();
   // Short rate periods keep the run brief; the rate test uses the shortest averaging
   htr_device #(.RATE_1HZ_PERIOD(600), .RATE_7HZ_PERIOD(400), .RATE_12HZ_PERIOD(300))
      htr_device_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link_if), .raw_hum_i(hum),
      .raw_temp_i(tmp), .calib_nvm_i(nvm), .active_o(act), .heater_o(heat),
      .converting_o(conv), .data_ready_o(drdy));
   htr_host htr_host_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_valid_i(cv),
      .cmd_write_i(cw), .cmd_addr_i(ca), .cmd_wdata_i(cd), .cmd_ready_o(rdy),
      .cmd_refused_o(refd), .rsp_valid_o(rv), .rsp_data_o(rdat), .link(link_if));
   htr_asserts htr_asserts_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr(link_if.addr),
      .wdata(link_if.wdata), .wr(link_if.wr), .rd(link_if.rd), .rdata(link_if.rdata));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic int period_of(input int code);
      return (code == 1) ? 600 : (code == 2) ? 400 : 300;
   endfunction : period_of

   task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d,
      output logic [7:0] v, output logic f);
      int k;
      @(posedge sys_clk_i);
      cv <= 1'b1;
      cw <= w;
      ca <= a;
      cd <= d;
      @(posedge sys_clk_i);
      cv <= 1'b0;
      #1;
      f = refd;
      v = 8'h00;
      k = 0;
      while (!w && f !== 1'b1 && rv !== 1'b1 && k < 8) begin
         @(posedge sys_clk_i);
         #1;
         k++;
      end
      if (rv === 1'b1) v = rdat;
      repeat (2) @(posedge sys_clk_i);
   endtask : xfer

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] v;
      logic f;
      xfer(1'b1, a, d, v, f);
   endtask : wr

   task automatic chk(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] v;
      logic f;
      xfer(1'b0, a, 8'h00, v, f);
      `CHK(v, e)
   endtask : chk

   // Counts cycles up to the next rising edge of the conversion flag
   task automatic wait_rise(output int m);
      m = 0;
      while (conv === 1'b1 && m < 2000) begin
         @(posedge sys_clk_i);
         #1;
         m++;
      end
      while (conv !== 1'b1 && m < 2000) begin
         @(posedge sys_clk_i);
         #1;
         m++;
      end
   endtask : wait_rise

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test

   initial begin
      forever #20 sys_clk_i = ~sys_clk_i;
   end

   initial begin
      #2400000;
      err_total++;
      stop_test();
   end

   initial begin
      nvm = {rnd(), rnd(), rnd(), rnd()};
      repeat (16) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (10) @(posedge sys_clk_i);
      `CHK(rdy, 1'b1)
      chk(ADDR_IDENT, IDENT_CODE);
      chk(ADDR_AVG, AVG_RST);
      chk(ADDR_RUN, RUN_RST);
      chk(ADDR_STATUS, 8'h00);
      chk(7'h7F, 8'h00);
      wr(ADDR_STATUS, 8'hFF);
      chk(ADDR_STATUS, 8'h00);
      wr(ADDR_HUM_L, 8'(rnd()));
      chk(ADDR_HUM_L, 8'h00);
      wr(ADDR_IDENT, 8'(rnd()));
      chk(ADDR_IDENT, IDENT_CODE);
      for (int k = 0; k < 16; k++) chk(ADDR_CALIB_LO + 7'(k), nvm[8*k +: 8]);
      repeat (4) begin
         q = 8'(rnd());
         wr(ADDR_AVG, q);
         chk(ADDR_AVG, q & AVG_MASK);
      end
      foreach (rsv[i]) begin
         xfer(1'b1, rsv[i], 8'hFF, q, r);
         `CHK(r, 1'b1)
      end
      $display("register test done");
      for (int c = 0; c < 8; c++) begin
         hum <= 16'(rnd());
         tmp <= 16'(rnd());
         wr(ADDR_AVG, {2'b00, 3'(c), 3'(c)});
         wr(ADDR_RUN, 8'h80);
         chk(ADDR_RUN, 8'h84);
         `CHK(act, 1'b1)
         wr(ADDR_SVC, 8'h01);
         wait_rise(n);
         // The sample that saw the rise is already one conversion cycle
         n = 1;
         while (conv === 1'b1 && n < 2000) begin
            @(posedge sys_clk_i);
            #1;
            n++;
         end
         `CHK(n >= (4 << c) && n <= (4 << c) + 2, 1'b1)
         chk(ADDR_STATUS, 8'h03);
         chk(ADDR_SVC, 8'h00);
         chk(ADDR_HUM_L, hum[7:0]);
         chk(ADDR_HUM_H, hum[15:8]);
         chk(ADDR_TEMP_L, tmp[7:0]);
         chk(ADDR_TEMP_H, tmp[15:8]);
         chk(ADDR_STATUS, 8'h00);
      end
      $display("conversion test done");
      // One half read before a new result: the other half must still show the old sample
      q = hum[15:8];
      prev_tmp = tmp;
      chk(ADDR_HUM_L, hum[7:0]);
      hum <= 16'(rnd());
      wr(ADDR_SVC, 8'h01);
      wait_rise(n);
      repeat (300) @(posedge sys_clk_i);
      // Past the temperature samples, so this change must not reach the result
      tmp <= ~prev_tmp;
      repeat (220) @(posedge sys_clk_i);
      chk(ADDR_HUM_H, q);
      chk(ADDR_HUM_L, hum[7:0]);
      chk(ADDR_HUM_H, hum[15:8]);
      chk(ADDR_TEMP_L, prev_tmp[7:0]);
      chk(ADDR_TEMP_H, prev_tmp[15:8]);
      $display("hold test done");
      wr(ADDR_SVC, 8'h02);
      `CHK(heat, 1'b1)
      xfer(1'b0, ADDR_HUM_L, 8'h00, q, r);
      `CHK(r, 1'b1)
      chk(ADDR_SVC, 8'h02);
      wr(ADDR_SVC, 8'h00);
      `CHK(heat, 1'b0)
      $display("heater test done");
      wr(ADDR_AVG, 8'h00);
      n = 0;
      repeat (700) begin
         @(posedge sys_clk_i);
         #1;
         if (conv === 1'b1) n++;
      end
      `CHK(n, 0)
      for (int c = 1; c < 4; c++) begin
         wr(ADDR_RUN, 8'h80 | 8'(c));
         wait_rise(n);
         wait_rise(n);
         `CHK(n >= period_of(c) - 2 && n <= period_of(c) + 2, 1'b1)
         chk(ADDR_STATUS, 8'h03);
      end
      wr(ADDR_RUN, 8'h00);
      `CHK(act, 1'b0)
      wr(ADDR_ALERT, 8'h04);
      `CHK(drdy, 1'b1)
      wr(ADDR_ALERT, 8'hFF);
      chk(ADDR_ALERT, ALERT_MASK);
      `CHK(drdy, 1'b0)
      $display("rate test done");
      nvm <= {rnd(), rnd(), rnd(), rnd()};
      wr(ADDR_SVC, 8'h80);
      repeat (10) @(posedge sys_clk_i);
      chk(ADDR_SVC, 8'h00);
      chk(ADDR_CALIB_LO, nvm[7:0]);
      chk(ADDR_CALIB_HI, nvm[127:120]);
      $display("reload test done");
      stop_test();
   end
endmodule : htr_bench
